// file: rtl/counter_array_compare.sv
// Purpose: Counter array with five compare modules, PWM and module 4 watchdog
// Assumes: Classic Wishbone slave, byte address, one register per aligned word
// Notes:   Watchdog reset clears this block for one cycle and is output only
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/10ps
module counter_array_compare (
  input  wire logic        clk_sys,           // System clock, 250 MHz
  input  wire logic        reset_n,           // Asynchronous reset, active low
  input  wire logic        wb_cyc_i,          // Wishbone cycle
  input  wire logic        wb_stb_i,          // Wishbone strobe
  input  wire logic        wb_we_i,           // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,          // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,          // Wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,          // Wishbone write data
  output logic      [31:0] wb_dat_o,          // Wishbone read data
  output logic             wb_ack_o,          // Wishbone acknowledge
  output logic      [4:0]  moduleComparePin,  // Compare or PWM pin per module
  output logic             wdInternalReset,   // Watchdog internal reset pulse
  output logic             moduleIrqRequest   // Any enabled event flag set
);

  localparam int N = counter_array_pkg::NUM_MODULES;

  logic [15:0] counter;
  logic        counterStepped;
  logic        counterRun;
  logic        overflowFlag;
  logic [4:0]  moduleEventFlag;
  logic        watchdogEnable;
  logic [7:0]  modeReg [N];
  logic [15:0] compareValue [N];
  logic [4:0]  match;
  logic [4:0]  flagEnable;
  logic [4:0]  irqEnable;
  logic [4:0]  pinFlop;
  logic        busWrite;
  logic        busRequest;
  logic        countWrite;
  logic        watchdogFire;
  counter_array_pkg::reg_sel_t sel;
  logic [2:0]  selIndex;
  logic [31:0] next_readData;

  // ===========================================================================
  // Address decode
  function automatic counter_array_pkg::reg_sel_t decodeSel(input logic [7:0] adr);
    counter_array_pkg::reg_sel_t s;
    s = counter_array_pkg::REG_NONE;
    if (adr == counter_array_pkg::CTRL_OFFSET) begin
      s = counter_array_pkg::REG_CTRL;
    end else if (adr == counter_array_pkg::CONFIG_OFFSET) begin
      s = counter_array_pkg::REG_CONFIG;
    end else if (adr == counter_array_pkg::COUNT_OFFSET) begin
      s = counter_array_pkg::REG_COUNT;
    end else if (adr >= counter_array_pkg::MODE_BASE && adr[1:0] == 2'b00
                 && adr < counter_array_pkg::MODE_BASE + 8'(N * 4)) begin
      s = counter_array_pkg::REG_MODE;
    end else if (adr >= counter_array_pkg::COMPARE_BASE && adr[1:0] == 2'b00
                 && adr < counter_array_pkg::COMPARE_BASE + 8'(N * 4)) begin
      s = counter_array_pkg::REG_COMPARE;
    end
    return s;
  endfunction

  function automatic logic [2:0] decodeIndex(input logic [7:0] adr, input logic [7:0] base);
    logic [7:0] d;
    d = adr - base;
    return d[4:2];
  endfunction

  assign sel        = decodeSel(wb_adr_i);
  assign selIndex   = (sel == counter_array_pkg::REG_MODE)
                    ? decodeIndex(wb_adr_i, counter_array_pkg::MODE_BASE)
                    : decodeIndex(wb_adr_i, counter_array_pkg::COMPARE_BASE);
  assign busRequest = wb_cyc_i & wb_stb_i;
  // A write lands on the edge where the master sees ack
  assign busWrite   = busRequest & wb_we_i & wb_ack_o;
  assign countWrite = busWrite && sel == counter_array_pkg::REG_COUNT && (wb_sel_i[1:0] != 2'b00);

  // ===========================================================================
  // Wishbone answer: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busRequest & ~wb_ack_o;
    end
  end

  always_comb begin
    next_readData = counter_array_pkg::READ_UNMAPPED;
    unique case (sel)
      counter_array_pkg::REG_CTRL: begin
        next_readData[counter_array_pkg::CTRL_OVF_BIT] = overflowFlag;
        next_readData[counter_array_pkg::CTRL_RUN_BIT] = counterRun;
        next_readData[4:0] = moduleEventFlag;
      end
      counter_array_pkg::REG_CONFIG: begin
        next_readData[counter_array_pkg::CONFIG_WD_EN_BIT] = watchdogEnable;
      end
      counter_array_pkg::REG_COUNT: begin
        next_readData[15:0] = counter;
      end
      counter_array_pkg::REG_MODE: begin
        next_readData[7:0] = modeReg[selIndex];
      end
      counter_array_pkg::REG_COMPARE: begin
        next_readData[15:0] = compareValue[selIndex];
      end
      counter_array_pkg::REG_NONE: begin
        next_readData = counter_array_pkg::READ_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= counter_array_pkg::READ_UNMAPPED;
    end else if (busRequest && !wb_ack_o) begin
      wb_dat_o <= next_readData;
    end
  end

  // ===========================================================================
  // Shared counter: single time base for every module
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      counter        <= counter_array_pkg::COUNT_RESET;
      counterStepped <= 1'b0;
    end else if (wdInternalReset) begin
      counter        <= counter_array_pkg::COUNT_RESET;
      counterStepped <= 1'b0;
    end else if (countWrite) begin
      // Rewriting the count moves the base for all modules
      if (wb_sel_i[0]) begin
        counter[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        counter[15:8] <= wb_dat_i[15:8];
      end
      counterStepped <= 1'b0;
    end else begin
      counter        <= counterRun ? counter + 16'h0001 : counter;
      counterStepped <= counterRun;
    end
  end

  // ===========================================================================
  // Control register: run bit, overflow and module event flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      counterRun      <= 1'b0;
      overflowFlag    <= 1'b0;
      moduleEventFlag <= 5'h00;
    end else if (wdInternalReset) begin
      counterRun      <= 1'b0;
      overflowFlag    <= 1'b0;
      moduleEventFlag <= 5'h00;
    end else begin
      if (busWrite && sel == counter_array_pkg::REG_CTRL && wb_sel_i[0]) begin
        counterRun <= wb_dat_i[counter_array_pkg::CTRL_RUN_BIT];
      end
      // Hardware set wins over a software clear in the same cycle
      overflowFlag <= ((busWrite && sel == counter_array_pkg::REG_CTRL && wb_sel_i[0])
                       ? wb_dat_i[counter_array_pkg::CTRL_OVF_BIT] : overflowFlag)
                    | (counterRun && !countWrite && counter == counter_array_pkg::COUNT_TOP);
      moduleEventFlag <= ((busWrite && sel == counter_array_pkg::REG_CTRL && wb_sel_i[0])
                          ? wb_dat_i[4:0] : moduleEventFlag)
                       | (match & flagEnable);
    end
  end

  // ===========================================================================
  // Configuration register: watchdog enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      watchdogEnable <= 1'b0;
    end else if (wdInternalReset) begin
      watchdogEnable <= 1'b0;
    end else if (busWrite && sel == counter_array_pkg::REG_CONFIG && wb_sel_i[0]) begin
      watchdogEnable <= wb_dat_i[counter_array_pkg::CONFIG_WD_EN_BIT];
    end
  end

  // ===========================================================================
  // Modules
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gModule
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          modeReg[g] <= counter_array_pkg::BYTE_RESET;
        end else if (wdInternalReset) begin
          modeReg[g] <= counter_array_pkg::BYTE_RESET;
        end else if (busWrite && sel == counter_array_pkg::REG_MODE && selIndex == 3'(g) && wb_sel_i[0]) begin
          modeReg[g] <= wb_dat_i[7:0] & counter_array_pkg::MODE_WRITE_MASK;
        end
      end

      assign flagEnable[g] = modeReg[g][counter_array_pkg::MODE_MATCH_EN_BIT]
                           & modeReg[g][counter_array_pkg::MODE_CMP_EN_BIT];
      assign irqEnable[g]  = modeReg[g][counter_array_pkg::MODE_FLAG_IRQ_BIT];

      // Every module sees the same counter, so PWM periods are equal
      compare_module uModule (
        .clk_sys        (clk_sys),
        .reset_n        (reset_n),
        .clear          (wdInternalReset),
        .counter        (counter),
        .counterStepped (counterStepped),
        .mode           (modeReg[g]),
        .wrLow          (busWrite && sel == counter_array_pkg::REG_COMPARE && selIndex == 3'(g) && wb_sel_i[0]),
        .wrHigh         (busWrite && sel == counter_array_pkg::REG_COMPARE && selIndex == 3'(g) && wb_sel_i[1]),
        .wrData         (wb_dat_i[15:0]),
        .compareValue   (compareValue[g]),
        .matchHit       (match[g]),
        .pin            (pinFlop[g])
      );
    end
  endgenerate

  assign moduleComparePin = pinFlop;

  // ===========================================================================
  // Watchdog on module 4 only; its other modes still run in parallel
  assign watchdogFire = watchdogEnable && match[counter_array_pkg::WD_MODULE];

  // Internal reset only; nothing here drives the external reset pin
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wdInternalReset <= 1'b0;
    end else begin
      wdInternalReset <= watchdogFire & ~wdInternalReset;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      moduleIrqRequest <= 1'b0;
    end else begin
      moduleIrqRequest <= |(moduleEventFlag & irqEnable);
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence wdPulse_s;
    wdInternalReset ##1 !wdInternalReset;
  endsequence

  sequence wdCleared_s;
    counter == counter_array_pkg::COUNT_RESET && !counterRun && !watchdogEnable && moduleEventFlag == 5'h00;
  endsequence

  run_stop_a: assert property (!counterRun && !countWrite && !wdInternalReset |=> $stable(counter))
    else $error("Counter moved while stopped");
  run_step_a: assert property (counterRun && !countWrite && !wdInternalReset |=> counter == $past(counter) + 16'h0001)
    else $error("Counter did not advance while running");
  flag_set_a: assert property ((match & flagEnable) != 5'h00 && !wdInternalReset
                               |=> (moduleEventFlag & $past(match & flagEnable)) == $past(match & flagEnable))
    else $error("Event flag not set on enabled match");
  wd_fire_a: assert property (watchdogFire && !wdInternalReset |=> wdPulse_s ##0 wdCleared_s)
    else $error("Watchdog match did not give a one-cycle reset that clears the block");
  wd_off_a: assert property (!watchdogEnable |=> !wdInternalReset)
    else $error("Internal reset without watchdog enabled");
  wd_only4_a: assert property (wdInternalReset |-> $past(match[counter_array_pkg::WD_MODULE]))
    else $error("Internal reset not caused by module 4 match");
  ack_pulse_a: assert property (busRequest && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone ack not a single cycle after request");

endmodule

// file: inc/counter_array_pkg.sv
// Purpose: Shared constants for the counter array compare, PWM and watchdog block
// Assumes: Registers reached over classic Wishbone, 32-bit data, byte addresses
// Notes:   Each register occupies one aligned word; unused upper bits read zero
package counter_array_pkg;

  // ===========================================================================
  // Geometry
  localparam int NUM_MODULES = 5;
  localparam int WD_MODULE   = 4;
  localparam int ADDR_WIDTH  = 8;

  // ===========================================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET  = 8'h04;
  localparam logic [7:0] COUNT_OFFSET   = 8'h08;
  localparam logic [7:0] MODE_BASE      = 8'h10;
  localparam logic [7:0] COMPARE_BASE   = 8'h30;
  localparam logic [7:0] REG_STRIDE     = 8'h04;

  // ===========================================================================
  // Field positions
  localparam int CTRL_OVF_BIT     = 7;
  localparam int CTRL_RUN_BIT     = 6;
  localparam int CONFIG_WD_EN_BIT  = 6;
  localparam int MODE_CMP_EN_BIT   = 6;
  localparam int MODE_MATCH_EN_BIT = 3;
  localparam int MODE_TOGGLE_BIT   = 2;
  localparam int MODE_PWM_BIT      = 1;
  localparam int MODE_FLAG_IRQ_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h7F;

  // ===========================================================================
  // Values after reset and fixed codes
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_TOP      = 16'hFFFF;
  localparam logic [7:0]  LOW_BYTE_WRAP  = 8'h00;
  localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

  // ===========================================================================
  // Register selection
  typedef enum logic [2:0] {
    REG_CTRL    = 3'b000,
    REG_CONFIG  = 3'b001,
    REG_COUNT   = 3'b010,
    REG_MODE    = 3'b011,
    REG_COMPARE = 3'b100,
    REG_NONE    = 3'b101
  } reg_sel_t;

endpackage

// file: rtl/compare_module.sv
// Purpose: One compare module: compare register, high-speed toggle and 8-bit PWM
// Assumes: Counter and its step pulse come from the shared counter in the parent
// Notes:   Pin is a flop; clear is the watchdog's internal reset, synchronous
`timescale 1ns/10ps
module compare_module (
  input  wire logic        clk_sys,       // System clock
  input  wire logic        reset_n,       // Asynchronous reset, active low
  input  wire logic        clear,         // Synchronous return to reset values
  input  wire logic [15:0] counter,       // Shared counter value
  input  wire logic        counterStepped,// Counter took a new count last edge
  input  wire logic [7:0]  mode,          // Module mode register
  input  wire logic        wrLow,         // Write compare low byte
  input  wire logic        wrHigh,        // Write compare high byte
  input  wire logic [15:0] wrData,        // Write data, high and low byte
  output logic      [15:0] compareValue,  // Compare register readback
  output logic             matchHit,      // Counter equals compare this cycle
  output logic             pin            // Module compare pin
);

  logic [7:0] compareLow;
  logic [7:0] compareHigh;
  logic       hsoMode;
  logic       pwmMode;
  logic       lowWrap;

  // ===========================================================================
  // Mode decode
  assign hsoMode = mode[counter_array_pkg::MODE_TOGGLE_BIT] & mode[counter_array_pkg::MODE_MATCH_EN_BIT]
                 & mode[counter_array_pkg::MODE_CMP_EN_BIT];
  assign pwmMode = mode[counter_array_pkg::MODE_PWM_BIT] & mode[counter_array_pkg::MODE_CMP_EN_BIT];
  // Only a fresh count may match, so a stopped counter cannot retrigger
  assign matchHit = counterStepped && (counter == {compareHigh, compareLow});
  assign lowWrap  = counterStepped && (counter[7:0] == counter_array_pkg::LOW_BYTE_WRAP);
  assign compareValue = {compareHigh, compareLow};

  // ===========================================================================
  // Compare register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      compareLow <= counter_array_pkg::BYTE_RESET;
    end else if (clear) begin
      compareLow <= counter_array_pkg::BYTE_RESET;
    end else if (wrLow) begin
      compareLow <= wrData[7:0];
    end else if (pwmMode && lowWrap) begin
      compareLow <= compareHigh;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      compareHigh <= counter_array_pkg::BYTE_RESET;
    end else if (clear) begin
      compareHigh <= counter_array_pkg::BYTE_RESET;
    end else if (wrHigh) begin
      compareHigh <= wrData[15:8];
    end
  end

  // ===========================================================================
  // Pin: PWM takes precedence over the toggle path when both modes are enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin <= 1'b0;
    end else if (clear) begin
      pin <= 1'b0;
    end else if (pwmMode) begin
      pin <= (counter[7:0] >= compareLow);
    end else if (hsoMode && matchHit) begin
      pin <= ~pin;
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  pwm_level_a: assert property (pwmMode && !clear |=> pin == ($past(counter[7:0]) >= $past(compareLow)))
    else $error("PWM pin level does not follow low byte compare");
  hso_toggle_a: assert property (hsoMode && !pwmMode && matchHit && !clear |=> pin != $past(pin))
    else $error("High-speed output did not toggle on match");
  pwm_reload_a: assert property (pwmMode && lowWrap && !wrLow && !clear |=> compareLow == $past(compareHigh))
    else $error("PWM duty not reloaded on low byte wrap");
  pin_idle_a: assert property (!hsoMode && !pwmMode && !clear |=> $stable(pin))
    else $error("Pin moved with neither output mode enabled");

endmodule

// file: sim/pin_load_model.sv
// Purpose: Load on one compare pin that measures its waveform
// Assumes: Pin is a registered level in the clk_sys domain
// Notes:   Figures cover the last full period, rising edge to rising edge
`timescale 1ns/10ps
module pin_load_model (
  input  wire logic        clk_sys,      // System clock
  input  wire logic        reset_n,      // Asynchronous reset, active low
  input  wire logic        pin,          // Observed compare pin
  output logic      [15:0] highCycles,   // High cycles in last period
  output logic      [15:0] periodCycles  // Length of last period
);
  // ==========================================================================
  // Period measurement
  logic        pinLast;
  logic [15:0] runHigh;
  logic [15:0] runPeriod;

  // A passive load: it never drives back, so it cannot mask a pin fault
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinLast      <= 1'b0;
      runHigh      <= 16'h0;
      runPeriod    <= 16'h0;
      highCycles   <= 16'h0;
      periodCycles <= 16'h0;
    end else begin
      pinLast <= pin;
      if (pin && !pinLast) begin
        highCycles   <= runHigh;
        periodCycles <= runPeriod;
        runHigh      <= 16'h1;
        runPeriod    <= 16'h1;
      end else begin
        runHigh   <= runHigh + {15'h0, pin};
        runPeriod <= runPeriod + 16'h1;
      end
    end
  end
endmodule

// file: sim/tb_counter_array_compare.sv
// Purpose: Self-checking bench for the compare, PWM and watchdog block
// Assumes: One-cycle Wishbone ack; counter steps once per clk_sys
// Notes:   Counter positions are reckoned from elapsed cycles with wide margins
`timescale 1ns/10ps
module tb_counter_array_compare;
  logic        clk_sys;
  logic        reset_n;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [4:0]  pins;
  logic        wdReset;
  logic        irq;
  logic [15:0] high2;
  logic [15:0] per2;
  logic [15:0] high3;
  logic [15:0] per3;
  logic [31:0] rdData;
  logic [31:0] saved;
  int          bad_count;
  int          tests_run;
  int          cycles;
  int          wdHigh;

  counter_array_compare dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .moduleComparePin(pins), .wdInternalReset(wdReset), .moduleIrqRequest(irq));
  pin_load_model load2_u (.clk_sys(clk_sys), .reset_n(reset_n), .pin(pins[2]), .highCycles(high2),
    .periodCycles(per2));
  pin_load_model load3_u (.clk_sys(clk_sys), .reset_n(reset_n), .pin(pins[3]), .highCycles(high3),
    .periodCycles(per3));

  // ==========================================================================
  // Clock, watchdog pulse counter and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (wdReset === 1'b1) wdHigh++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled; a dead slave is caught by the cycle guard
  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbSel  <= s;
    wbDatW <= d;
    do begin
      @(posedge clk_sys);
    end while (wbAck !== 1'b1);
    rdData = wbDatO;
    chk({31'h0, wbAck}, 32'h1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'hF, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hF, 32'h0);
    chk(rdData, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task finish_test;
    $display("TB: tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    reset_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h0;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    wdHigh = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdc(counter_array_pkg::CTRL_OFFSET, 32'h0);
    rdc(counter_array_pkg::MODE_BASE, 32'h0);
    rdc(8'h80, counter_array_pkg::READ_UNMAPPED);
    wr(8'h14, 32'hFF);
    rdc(8'h14, 32'h7F);
    $display("TB: test reset and decode done");
    wr(8'h14, 32'h0C);
    wr(8'h10, 32'h4D);
    wr(8'h1C, 32'h44);
    wr(8'h20, 32'h4C);
    for (int i = 0; i < 5; i++) wr(counter_array_pkg::COMPARE_BASE + 8'(i * 4), 32'h20);
    wr(counter_array_pkg::CTRL_OFFSET, 32'h40);
    idle(60);
    // Pin 1 keeps the high level it took during its brief PWM setting at count 0
    chk({27'h0, pins}, 32'h13);
    rdc(counter_array_pkg::CTRL_OFFSET, 32'h51);
    chk({31'h0, irq}, 32'h1);
    wr(counter_array_pkg::CTRL_OFFSET, 32'h0);
    bus(1'b0, counter_array_pkg::COUNT_OFFSET, 4'hF, 32'h0);
    saved = rdData;
    idle(10);
    rdc(counter_array_pkg::COUNT_OFFSET, saved);
    chk({31'h0, irq}, 32'h0);
    $display("TB: test toggle output done");
    wr(8'h18, 32'h42);
    wr(8'h1C, 32'h42);
    wr(8'h38, 32'h8080);
    wr(8'h3C, 32'h4040);
    wr(counter_array_pkg::CTRL_OFFSET, 32'h40);
    idle(800);
    chk({16'h0, high2}, 32'h80);
    chk({16'h0, high3}, 32'hC0);
    chk({16'h0, per2}, 32'h100);
    chk({16'h0, per3}, 32'h100);
    bus(1'b1, 8'h38, 4'h2, 32'hC000);
    idle(800);
    rdc(8'h38, 32'hC0C0);
    chk({16'h0, high2}, 32'h40);
    $display("TB: test pwm done");
    wr(counter_array_pkg::CTRL_OFFSET, 32'h0);
    wr(counter_array_pkg::COUNT_OFFSET, 32'h0);
    wr(8'h40, 32'h0100);
    wr(counter_array_pkg::CONFIG_OFFSET, 32'h40);
    wr(counter_array_pkg::CTRL_OFFSET, 32'h40);
    idle(150);
    wr(8'h40, 32'h0300);
    idle(400);
    wr(counter_array_pkg::CONFIG_OFFSET, 32'h0);
    idle(400);
    chk(32'(wdHigh), 32'h0);
    wr(8'h40, 32'h0500);
    wr(counter_array_pkg::CONFIG_OFFSET, 32'h40);
    idle(400);
    chk(32'(wdHigh), 32'h1);
    chk({31'h0, reset_n}, 32'h1);
    rdc(counter_array_pkg::CTRL_OFFSET, 32'h0);
    rdc(8'h18, 32'h0);
    chk({27'h0, pins}, 32'h0);
    $display("TB: test watchdog done");
    finish_test();
  end
endmodule
